/* rtl/dtc_defs.svh */
// offsets, field positions, reset values and divide counts of the dual timer/counter
// What this block does
// - enabled timer in timer mode advances once per prescaled tick, default twelve clocks
// - timer zero divide-select bit 3: one gives divide by 4, zero divide by 12
// - timer one divide-select bit 4: one gives divide by 4, zero divide by 12
// - counter mode increments on each falling edge of the sampled count input
// - timer one flag cleared by interrupt entry and by software writing zero
// - timer zero flag cleared by interrupt entry and by software writing zero
// - a timer counts only while its run bit is set, else holds
// - gate bit set makes the external gate input qualify counting
// - count-select one takes external input as clock, zero the prescaled clock
// - mode register: timer one fields bits 7..4, timer zero bits 3..0, resets zero
// - control register: flag one, run one, flag zero, run zero, low nibble external
// - mode 00: low byte 5-bit prescaler feeding high byte, 13 bits
// - mode 01: both bytes cascade into one 16-bit up-counter
// - mode 10: low byte counts, reloads from unchanged high byte on overflow
// - timer zero mode 11: two 8-bit counters, high byte uses timer one controls
// - only timer zero splits; timer one then counts but raises no flag
`ifndef DTC_DEFS_SVH
`define DTC_DEFS_SVH

// ==========================================
// register indices (byte address is four times the index)
`define DTC_IDX_CTRL 8'h88
`define DTC_IDX_MODE 8'h89
`define DTC_IDX_T0LO 8'h8a
`define DTC_IDX_T1LO 8'h8b
`define DTC_IDX_T0HI 8'h8c
`define DTC_IDX_T1HI 8'h8d
`define DTC_IDX_CKDIV 8'h8e
`define DTC_IDX_ISTAT 8'h90
`define DTC_IDX_ICLR 8'h91
`define DTC_IDX_IEN 8'h92

// ==========================================
// field positions
`define DTC_CTRL_TF1 7
`define DTC_CTRL_TR1 6
`define DTC_CTRL_TF0 5
`define DTC_CTRL_TR0 4
`define DTC_CK_T1DIV 4
`define DTC_CK_T0DIV 3
`define DTC_ISTAT_T0 0
`define DTC_ISTAT_T1 1

// ==========================================
// reset values and divide counts
`define DTC_RST_CTRL 8'h00
`define DTC_RST_MODE 8'h00
`define DTC_RST_CKDIV 8'hc7
`define DTC_RST_COUNT 8'h00
`define DTC_DIV_SLOW 12
`define DTC_DIV_FAST 4

`endif

/* rtl/dtc_pkg.sv */
// types shared by the dual timer/counter
package dtc_pkg;
	typedef enum logic [1:0]
	{
		DTC_MODE_13BIT = 2'b00,
		DTC_MODE_16BIT = 2'b01,
		DTC_MODE_RELOAD = 2'b10,
		DTC_MODE_SPLIT = 2'b11
	} dtc_mode_e;
	typedef logic [16:0] dtc_count_t;
endpackage

/* rtl/dtc_top.sv */
// dual 16-bit timer/counter with apb register access and a level interrupt
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dtc_defs.svh"

module dtc_top
	import dtc_pkg::*;
#(
	parameter int ADDR_W = 12
)
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic tmr_zero_count_input,
	input wire logic tmr_one_count_input,
	input wire logic tmr_zero_gate_input,
	input wire logic tmr_one_gate_input,
	input wire logic irq_ack_zero,
	input wire logic irq_ack_one,
	output logic tmr_zero_overflow_flag,
	output logic tmr_one_overflow_flag,
	output logic irq
);

	// ==========================================
	// functions
	function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
		reg_index = a[9:2];
	endfunction

	function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
		logic [7:0] i;
		i = a[9:2];
		reg_mapped = (a[1:0] == 2'b00) && (a[ADDR_W-1:10] == '0)
			&& (((i >= `DTC_IDX_CTRL) && (i <= `DTC_IDX_CKDIV)) || ((i >= `DTC_IDX_ISTAT) && (i <= `DTC_IDX_IEN)));
	endfunction

	// one increment of a counter pair; result is {overflow, high, low}
	function automatic dtc_count_t count_step(input logic [1:0] mode, input logic [7:0] lo, input logic [7:0] hi);
		dtc_count_t r;
		r = {1'b0, hi, lo};
		unique case (dtc_mode_e'(mode))
			DTC_MODE_13BIT:
			begin
				// upper three bits of the low byte are left alone
				r[4:0] = lo[4:0] + 5'd1;
				if (lo[4:0] == 5'h1f)
				begin
					r[15:8] = hi + 8'd1;
					r[16] = (hi == 8'hff);
				end
			end
			DTC_MODE_16BIT:
				r = {1'b0, hi, lo} + 17'd1;
			DTC_MODE_RELOAD:
			begin
				r[7:0] = (lo == 8'hff) ? hi : lo + 8'd1;
				r[16] = (lo == 8'hff);
			end
			DTC_MODE_SPLIT:
			begin
				r[7:0] = lo + 8'd1;
				r[16] = (lo == 8'hff);
			end
		endcase
		count_step = r;
	endfunction

	// ==========================================
	// registers
	logic [7:0] ctrl;
	logic [7:0] mode;
	logic [7:0] ckdiv;
	logic [7:0] t0_lo;
	logic [7:0] t0_hi;
	logic [7:0] t1_lo;
	logic [7:0] t1_hi;
	logic [1:0] int_status;
	logic [1:0] int_enable;
	logic [3:0] pre_cnt;
	logic [2:0] cnt0_sync;
	logic [2:0] cnt1_sync;
	logic [1:0] tmr_zero_gate_enable_sync;
	logic [1:0] tmr_one_gate_enable_sync;

	// ==========================================
	// apb slave: setup cycle, then one access cycle with pready high
	logic acc;
	logic wr;
	logic [7:0] widx;
	logic [7:0] wbyte;
	assign acc = psel && penable && pready;
	assign wr = acc && pwrite && reg_mapped(paddr);
	assign widx = reg_index(paddr);
	assign wbyte = pwdata[7:0];

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else if (ce)
		begin
			pready <= psel && !penable && !pready;
			if (psel && !penable && !pready)
			begin
				pslverr <= !reg_mapped(paddr);
				prdata <= 32'h0000_0000;
				if (reg_mapped(paddr) && !pwrite)
				begin
					unique case (reg_index(paddr))
						`DTC_IDX_CTRL: prdata[7:0] <= ctrl;
						`DTC_IDX_MODE: prdata[7:0] <= mode;
						`DTC_IDX_T0LO: prdata[7:0] <= t0_lo;
						`DTC_IDX_T1LO: prdata[7:0] <= t1_lo;
						`DTC_IDX_T0HI: prdata[7:0] <= t0_hi;
						`DTC_IDX_T1HI: prdata[7:0] <= t1_hi;
						`DTC_IDX_CKDIV: prdata[7:0] <= ckdiv;
						`DTC_IDX_ISTAT: prdata[1:0] <= int_status;
						`DTC_IDX_IEN: prdata[1:0] <= int_enable;
						default: prdata <= 32'h0000_0000;
					endcase
				end
			end
		end
	end

	// ==========================================
	// pin synchronisers; the first stage feeds only the second
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			cnt0_sync <= 3'b111;
			cnt1_sync <= 3'b111;
			tmr_zero_gate_enable_sync <= 2'b00;
			tmr_one_gate_enable_sync <= 2'b00;
		end
		else if (ce)
		begin
			cnt0_sync <= {cnt0_sync[1:0], tmr_zero_count_input};
			cnt1_sync <= {cnt1_sync[1:0], tmr_one_count_input};
			tmr_zero_gate_enable_sync <= {tmr_zero_gate_enable_sync[0], tmr_zero_gate_input};
			tmr_one_gate_enable_sync <= {tmr_one_gate_enable_sync[0], tmr_one_gate_input};
		end
	end

	logic fall0;
	logic fall1;
	assign fall0 = cnt0_sync[2] && !cnt0_sync[1];
	assign fall1 = cnt1_sync[2] && !cnt1_sync[1];

	// ==========================================
	// shared prescaler: one modulo-twelve counter gives both tick rates
	logic tick_slow;
	logic tick_fast;
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			pre_cnt <= 4'd0;
		else if (ce)
			pre_cnt <= (pre_cnt == 4'(`DTC_DIV_SLOW - 1)) ? 4'd0 : pre_cnt + 4'd1;
	end
	assign tick_slow = (pre_cnt == 4'(`DTC_DIV_SLOW - 1));
	assign tick_fast = (pre_cnt[1:0] == 2'(`DTC_DIV_FAST - 1));

	logic pre0;
	logic pre1;
	assign pre0 = ckdiv[`DTC_CK_T0DIV] ? tick_fast : tick_slow;
	assign pre1 = ckdiv[`DTC_CK_T1DIV] ? tick_fast : tick_slow;

	// ==========================================
	// count enables
	logic split;
	logic inc0;
	logic inc0_hi;
	logic inc1;
	assign split = (mode[1:0] == 2'b11);
	assign inc0 = ctrl[`DTC_CTRL_TR0] && (!mode[3] || tmr_zero_gate_enable_sync[1]) && (mode[2] ? fall0 : pre0);
	// split high byte: timer only, run bit and gate of timer one
	assign inc0_hi = split && ctrl[`DTC_CTRL_TR1] && (!mode[7] || tmr_one_gate_enable_sync[1]) && pre0;
	assign inc1 = ctrl[`DTC_CTRL_TR1] && (!mode[7] || tmr_one_gate_enable_sync[1]) && (mode[6] ? fall1 : pre1)
		&& (mode[5:4] != 2'b11);

	dtc_count_t step0;
	dtc_count_t step1;
	assign step0 = count_step(mode[1:0], t0_lo, t0_hi);
	assign step1 = count_step(mode[5:4], t1_lo, t1_hi);

	logic ovf0;
	logic ovf0_hi;
	logic ovf1;
	logic flag1_set;
	assign ovf0 = inc0 && step0[16];
	assign ovf0_hi = inc0_hi && (t0_hi == 8'hff);
	assign ovf1 = inc1 && step1[16];
	// timer one keeps counting but its flag belongs to timer zero while split
	assign flag1_set = split ? ovf0_hi : ovf1;

	// ==========================================
	// timer zero count bytes; a register write wins over a count
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			t0_lo <= `DTC_RST_COUNT;
			t0_hi <= `DTC_RST_COUNT;
		end
		else if (ce)
		begin
			if (wr && widx == `DTC_IDX_T0LO)
				t0_lo <= wbyte;
			else if (inc0)
				t0_lo <= step0[7:0];
			if (wr && widx == `DTC_IDX_T0HI)
				t0_hi <= wbyte;
			else if (inc0_hi)
				t0_hi <= t0_hi + 8'd1;
			else if (inc0 && !split)
				t0_hi <= step0[15:8];
		end
	end

	// ==========================================
	// timer one count bytes
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			t1_lo <= `DTC_RST_COUNT;
			t1_hi <= `DTC_RST_COUNT;
		end
		else if (ce)
		begin
			if (wr && widx == `DTC_IDX_T1LO)
				t1_lo <= wbyte;
			else if (inc1)
				t1_lo <= step1[7:0];
			if (wr && widx == `DTC_IDX_T1HI)
				t1_hi <= wbyte;
			else if (inc1)
				t1_hi <= step1[15:8];
		end
	end

	// ==========================================
	// control, mode and divide registers
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			ctrl <= `DTC_RST_CTRL;
			mode <= `DTC_RST_MODE;
			ckdiv <= `DTC_RST_CKDIV;
		end
		else if (ce)
		begin
			if (wr && widx == `DTC_IDX_MODE)
				mode <= wbyte;
			if (wr && widx == `DTC_IDX_CKDIV)
				ckdiv <= wbyte;
			if (wr && widx == `DTC_IDX_CTRL)
				ctrl <= wbyte;
			// set wins over software write and interrupt entry
			if (ovf0)
				ctrl[`DTC_CTRL_TF0] <= 1'b1;
			else if (irq_ack_zero)
				ctrl[`DTC_CTRL_TF0] <= 1'b0;
			if (flag1_set)
				ctrl[`DTC_CTRL_TF1] <= 1'b1;
			else if (irq_ack_one)
				ctrl[`DTC_CTRL_TF1] <= 1'b0;
		end
	end
	assign tmr_zero_overflow_flag = ctrl[`DTC_CTRL_TF0];
	assign tmr_one_overflow_flag = ctrl[`DTC_CTRL_TF1];

	// ==========================================
	// sticky interrupt status, write-one-to-clear, enable
	logic [1:0] events;
	logic [1:0] clr;
	assign events = {flag1_set, ovf0};
	assign clr = (wr && widx == `DTC_IDX_ICLR) ? pwdata[1:0] : 2'b00;

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			int_status <= 2'b00;
			int_enable <= 2'b00;
			irq <= 1'b0;
		end
		else if (ce)
		begin
			int_status <= (int_status & ~clr) | events;
			if (wr && widx == `DTC_IDX_IEN)
				int_enable <= pwdata[1:0];
			irq <= |(int_status & int_enable);
		end
	end

	// ==========================================
	// checks
	slow_tick_phase_a: assert property (@(posedge clk_sys) disable iff (reset)
		(ce && tick_slow) |=> (pre_cnt == 4'd0))
		else $error("slow tick not at end of twelve-cycle period");

	t0_div_a: assert property (@(posedge clk_sys) disable iff (reset)
		(inc0 && !mode[2] && !ckdiv[`DTC_CK_T0DIV]) |-> (pre_cnt == 4'd11))
		else $error("timer zero counted off the divide-by-twelve tick");

	t1_div_a: assert property (@(posedge clk_sys) disable iff (reset)
		(inc1 && !mode[6] && ckdiv[`DTC_CK_T1DIV]) |-> (pre_cnt[1:0] == 2'd3))
		else $error("timer one counted off the divide-by-four tick");

	t0_cascade_a: assert property (@(posedge clk_sys) disable iff (reset)
		(ce && inc0 && mode[1:0] == 2'b01 && !(acc && pwrite)) |=> ({t0_hi, t0_lo} == $past({t0_hi, t0_lo}) + 16'd1))
		else $error("timer zero 16-bit count did not advance by one");

	t0_halt_a: assert property (@(posedge clk_sys) disable iff (reset)
		(ce && !ctrl[`DTC_CTRL_TR0] && !(acc && pwrite)) |=> (t0_lo == $past(t0_lo)))
		else $error("timer zero low byte moved while stopped");

	t1_mode3_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
		(ce && mode[5:4] == 2'b11 && !(acc && pwrite)) |=> ({t1_hi, t1_lo} == $past({t1_hi, t1_lo})))
		else $error("timer one moved in mode three");

	t0_reload_a: assert property (@(posedge clk_sys) disable iff (reset)
		(ce && inc0 && mode[1:0] == 2'b10 && t0_lo == 8'hff && !(acc && pwrite)) |=> (t0_lo == $past(t0_hi) && ctrl[5]))
		else $error("timer zero reload or flag missing");

	t0_ack_a: assert property (@(posedge clk_sys) disable iff (reset)
		(ce && irq_ack_zero && !ovf0) |=> !ctrl[`DTC_CTRL_TF0])
		else $error("timer zero flag not cleared on interrupt entry");

	t1_ack_a: assert property (@(posedge clk_sys) disable iff (reset)
		(ce && irq_ack_one && !flag1_set) |=> !ctrl[`DTC_CTRL_TF1])
		else $error("timer one flag not cleared on interrupt entry");

	split_flag_a: assert property (@(posedge clk_sys) disable iff (reset)
		(ce && split && ovf1 && !ovf0_hi && !ctrl[7] && !(acc && pwrite)) |=> !ctrl[`DTC_CTRL_TF1])
		else $error("timer one raised its flag while timer zero is split");

	irq_path_a: assert property (@(posedge clk_sys) disable iff (reset)
		(ce && ovf0 && int_enable[0] && !(acc && pwrite)) |=> int_status[0] ##1 (!$past(ce) || irq))
		else $error("timer zero overflow did not reach the interrupt");

	t1_reload_a: assert property (@(posedge clk_sys) disable iff (reset)
		(ce && inc1 && !split && mode[5:4] == 2'b10 && t1_lo == 8'hff && !(acc && pwrite))
		|=> (t1_lo == $past(t1_hi) && ctrl[`DTC_CTRL_TF1]))
		else $error("timer one reload or flag missing");

endmodule // dtc_top

`default_nettype wire

/* bench/tb_dtc_top.sv */
// self-checking bench of the dual timer/counter
`timescale 1ns/1ps
`default_nettype none
`include "dtc_defs.svh"

module tb_dtc_top;
	// ==========================================
	// signals and tables
	typedef struct {logic [7:0] ck, md, ct, ia, ib, ea, eb;} dtc_row_s;
	localparam logic [7:0] LO0 = `DTC_IDX_T0LO, HI0 = `DTC_IDX_T0HI, LO1 = `DTC_IDX_T1LO;
	logic clk_sys, reset, ce, psel, penable, pwrite, pready, pslverr, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdata;
	logic cnt0, cnt1, tmr_zero_gate_enable, tmr_one_gate_enable, ack0, ack1, flag0, flag1, rerr;
	logic [7:0] a0, b0, d8;
	int num_errors = 0;
	int comparisons = 0;
	// diffs seen over 24 clocks: 2 ticks at divide 12, 6 at divide 4
	dtc_row_s rows [9] = '{
		'{8'hc7, 8'h11, 8'h50, LO0, LO1, 8'h02, 8'h02},
		'{8'hcf, 8'h11, 8'h50, LO0, LO1, 8'h06, 8'h02},
		'{8'hd7, 8'h11, 8'h50, LO0, LO1, 8'h02, 8'h06},
		'{8'hc7, 8'h11, 8'h00, LO0, LO1, 8'h00, 8'h00},
		'{8'hc7, 8'h19, 8'h50, LO0, LO1, 8'h00, 8'h02},
		'{8'hc7, 8'h13, 8'h10, LO0, HI0, 8'h02, 8'h00},
		'{8'hc7, 8'h13, 8'h40, LO0, HI0, 8'h00, 8'h02},
		'{8'hc7, 8'h13, 8'h40, LO1, HI0, 8'h02, 8'h02},
		'{8'hc7, 8'h31, 8'h50, LO0, LO1, 8'h02, 8'h00}};

	dtc_top u_dut (.clk_sys(clk_sys), .reset(reset), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tmr_zero_count_input(cnt0), .tmr_one_count_input(cnt1),
		.tmr_zero_gate_input(tmr_zero_gate_enable), .tmr_one_gate_input(tmr_one_gate_enable), .irq_ack_zero(ack0),
		.irq_ack_one(ack1), .tmr_zero_overflow_flag(flag0), .tmr_one_overflow_flag(flag1), .irq(irq));

	// ==========================================
	// tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one idle edge after each transfer keeps psel from being driven twice in a step
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {24'h00_0000, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1 && n < 20)
		begin
			@(posedge clk_sys);
			n++;
		end
		if (n == 20)
			num_errors++;
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		xfer(1'b1, idx, d);
	endtask

	task automatic rd(input logic [7:0] idx);
		xfer(1'b0, idx, 8'h00);
	endtask

	task automatic pulses(input int k);
		repeat (k)
		begin
			cnt0 <= 1'b0;
			cnt1 <= 1'b0;
			repeat (4) @(posedge clk_sys);
			cnt0 <= 1'b1;
			cnt1 <= 1'b1;
			repeat (4) @(posedge clk_sys);
		end
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ==========================================
	// clock, watchdog and tests
	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	initial
	begin
		repeat (20000) @(posedge clk_sys);
		num_errors++;
		print_verdict();
	end

	initial
	begin
		{reset, ce, psel, penable, pwrite, paddr, pwdata} = {2'b11, 47'h0};
		{cnt0, cnt1, tmr_zero_gate_enable, tmr_one_gate_enable, ack0, ack1} = 6'b110000;
		repeat (20) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		foreach (rows[i])
		begin
			wr(`DTC_IDX_CKDIV, rows[i].ck);
			wr(`DTC_IDX_MODE, rows[i].md);
			wr(`DTC_IDX_CTRL, rows[i].ct);
			rd(rows[i].ia);
			a0 = rdata[7:0];
			rd(rows[i].ib);
			b0 = rdata[7:0];
			repeat (18) @(posedge clk_sys);
			rd(rows[i].ia);
			d8 = rdata[7:0] - a0;
			chk(d8, rows[i].ea);
			rd(rows[i].ib);
			d8 = rdata[7:0] - b0;
			chk(d8, rows[i].eb);
		end
		// 24 enabled edges around a 30-edge freeze still give exactly two ticks
		rd(LO0);
		a0 = rdata[7:0];
		repeat (6) @(posedge clk_sys);
		ce <= 1'b0;
		repeat (30) @(posedge clk_sys);
		ce <= 1'b1;
		repeat (15) @(posedge clk_sys);
		rd(LO0);
		d8 = rdata[7:0] - a0;
		chk(d8, 8'h02);
		$display("test done: rates");
		wr(`DTC_IDX_MODE, 8'h55);
		wr(`DTC_IDX_CTRL, 8'h50);
		wr(LO0, 8'h00);
		wr(LO1, 8'h00);
		pulses(5);
		rd(LO0);
		chk(rdata, 32'h0000_0005);
		rd(LO1);
		chk(rdata, 32'h0000_0005);
		wr(`DTC_IDX_MODE, 8'hdd);
		pulses(3);
		rd(LO1);
		chk(rdata, 32'h0000_0005);
		{tmr_zero_gate_enable, tmr_one_gate_enable} <= 2'b11;
		repeat (4) @(posedge clk_sys);
		pulses(3);
		rd(LO0);
		chk(rdata, 32'h0000_0008);
		$display("test done: counter");
		// run bit first: a later control write would clear the fresh flag
		wr(`DTC_IDX_CKDIV, 8'hcf);
		wr(`DTC_IDX_MODE, 8'h00);
		wr(`DTC_IDX_CTRL, 8'h10);
		wr(HI0, 8'hff);
		wr(LO0, 8'hff);
		repeat (8) @(posedge clk_sys);
		#1 chk(flag0, 1'b1);
		rd(HI0);
		chk(rdata, 32'h0000_0000);
		rd(LO0);
		chk(rdata[7:5], 3'b111);
		ack0 <= 1'b1;
		@(posedge clk_sys);
		ack0 <= 1'b0;
		@(posedge clk_sys);
		#1 chk(flag0, 1'b0);
		$display("test done: mode zero");
		wr(`DTC_IDX_CTRL, 8'h00);
		wr(`DTC_IDX_CKDIV, 8'hd7);
		wr(`DTC_IDX_MODE, 8'h20);
		wr(`DTC_IDX_T1HI, 8'hfe);
		wr(LO1, 8'hfe);
		wr(`DTC_IDX_CTRL, 8'h40);
		repeat (16) @(posedge clk_sys);
		#1 chk(flag1, 1'b1);
		ack1 <= 1'b1;
		@(posedge clk_sys);
		ack1 <= 1'b0;
		@(posedge clk_sys);
		#1 chk(flag1, 1'b0);
		repeat (8) @(posedge clk_sys);
		#1 chk(flag1, 1'b1);
		// stop first so no overflow can meet the clearing write
		wr(`DTC_IDX_CTRL, 8'h80);
		chk(flag1, 1'b1);
		wr(`DTC_IDX_CTRL, 8'h00);
		chk(flag1, 1'b0);
		rd(`DTC_IDX_T1HI);
		chk(rdata, 32'h0000_00fe);
		rd(LO1);
		chk(rdata[7:1], 7'h7f);
		$display("test done: reload");
		// status holds both flag events now; mask and raise them, clear the timer one event only
		wr(`DTC_IDX_IEN, 8'h02);
		@(posedge clk_sys);
		#1 chk(irq, 1'b1);
		wr(`DTC_IDX_ICLR, 8'h02);
		@(posedge clk_sys);
		#1 chk(irq, 1'b0);
		wr(`DTC_IDX_ISTAT, 8'h00);
		rd(`DTC_IDX_ISTAT);
		chk(rdata, 32'h0000_0001);
		wr(`DTC_IDX_IEN, 8'h01);
		@(posedge clk_sys);
		#1 chk(irq, 1'b1);
		rd(`DTC_IDX_ICLR);
		chk(rdata, 32'h0000_0000);
		rd(8'h80);
		chk({rerr, rdata[30:0]}, {1'b1, 31'h0000_0000});
		$display("test done: interrupt");
		wr(`DTC_IDX_MODE, 8'ha5);
		rd(`DTC_IDX_MODE);
		chk(rdata, 32'h0000_00a5);
		reset <= 1'b1;
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		chk({irq, flag0, flag1}, 3'b000);
		rd(`DTC_IDX_MODE);
		chk(rdata, 32'h0000_0000);
		rd(`DTC_IDX_CTRL);
		chk(rdata, 32'h0000_0000);
		rd(`DTC_IDX_CKDIV);
		chk(rdata, 32'h0000_00c7);
		$display("test done: reset");
		print_verdict();
	end
endmodule // tb_dtc_top

`default_nettype wire
